//--- core/rsoc_cfg_guard.sv
`timescale 1ns/10ps
module rsoc_cfg_guard #(
   parameter int NCFG = rsoc_pkg::NCFG
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // phase and strap
   input wire logic open,
   input wire logic clear,
   input wire logic always_writable,
   // write requests and grants
   input wire logic [NCFG-1:0] cfg_wr,
   output logic [NCFG-1:0] cfg_wr_ok
);
   logic [NCFG-1:0] done;
   logic [NCFG-1:0] next_done;
   logic [NCFG-1:0] next_ok;

   always_comb begin
      // one write each unless the strap makes them always writable
      next_ok = cfg_wr & {NCFG{open}} & (always_writable ? {NCFG{1'b1}} : ~done);
      next_done = clear ? {NCFG{1'b0}} : (done | next_ok);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         done <= '0;
         cfg_wr_ok <= '0;
      end else begin
         done <= next_done;
         cfg_wr_ok <= next_ok;
      end
   end
endmodule : rsoc_cfg_guard

//--- core/rsoc_pad_ctrl.sv
`timescale 1ns/10ps
module rsoc_pad_ctrl #(
   parameter int NPAD = rsoc_pkg::NPAD
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // phase and identity
   input wire logic hold,
   input wire logic id_zero,
   // core function side
   input wire logic [NPAD-1:0] func_out,
   input wire logic [NPAD-1:0] func_oe,
   // pad side
   output logic [NPAD-1:0] pad_out,
   output logic [NPAD-1:0] pad_oe,
   output logic [NPAD-1:0] pad_pull_up,
   output logic [NPAD-1:0] pad_pull_down
);
   logic [NPAD-1:0] next_pad_out;
   logic [NPAD-1:0] next_pad_oe;
   logic [NPAD-1:0] next_pad_pull_up;
   logic [NPAD-1:0] next_pad_pull_down;
   logic [NPAD-1:0] id_mask;

   always_comb begin
      // id-gated pulls exist only on the owner device
      id_mask = id_zero ? {NPAD{1'b1}} : ~rsoc_pkg::ID_ZERO_ONLY;
      if (hold) begin
         next_pad_out = rsoc_pkg::ALL_ZERO;
         next_pad_oe = rsoc_pkg::ALL_ZERO;
         next_pad_pull_up = rsoc_pkg::HOLD_PULL_UP & id_mask;
         next_pad_pull_down = rsoc_pkg::HOLD_PULL_DOWN & id_mask;
      end else begin
         next_pad_out = func_out;
         next_pad_oe = func_oe;
         next_pad_pull_up = rsoc_pkg::RUN_PULL_UP & id_mask;
         next_pad_pull_down = rsoc_pkg::ALL_ZERO;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pad_out <= rsoc_pkg::ALL_ZERO;
         pad_oe <= rsoc_pkg::ALL_ZERO;
         pad_pull_up <= rsoc_pkg::RESET_PULL_UP;
         pad_pull_down <= rsoc_pkg::RESET_PULL_DOWN;
      end else begin
         pad_out <= next_pad_out;
         pad_oe <= next_pad_oe;
         pad_pull_up <= next_pad_pull_up;
         pad_pull_down <= next_pad_pull_down;
      end
   end
endmodule : rsoc_pad_ctrl

//--- core/rsoc_pkg.sv
package rsoc_pkg;
   // pad positions of the shared strap pins
   localparam int NPAD = 7;
   localparam int PAD_BOOT = 0;
   localparam int PAD_IRQ = 1;
   localparam int PAD_LINK = 2;
   localparam int PAD_CFGW = 3;
   localparam int PAD_TST1 = 4;
   localparam int PAD_TST2 = 5;
   localparam int PAD_TST3 = 6;

   // strap values when pins are left to the internal pulls
   localparam logic [NPAD-1:0] STRAP_DEFAULT = 7'h70;

   // pad resistor table, reset held versus normal operation
   localparam logic [NPAD-1:0] HOLD_PULL_DOWN = 7'h0F;
   localparam logic [NPAD-1:0] HOLD_PULL_UP = 7'h70;
   localparam logic [NPAD-1:0] RUN_PULL_UP = 7'h09;
   localparam logic [NPAD-1:0] RUN_DRIVEN = 7'h76;
   localparam logic [NPAD-1:0] ID_ZERO_ONLY = 7'h09;
   localparam logic [NPAD-1:0] ALL_ZERO = 7'h00;

   // pulls that apply at power-on reset without knowing the identifier
   localparam logic [NPAD-1:0] RESET_PULL_DOWN = 7'h06;
   localparam logic [NPAD-1:0] RESET_PULL_UP = 7'h70;

   // configuration registers guarded by the write strap
   localparam int NCFG = 2;
   localparam int CFG_SYS = 0;
   localparam int CFG_SDRAM = 1;

   // identifier width and the value that owns the id-gated pulls
   localparam int ID_W = 3;
   localparam logic [ID_W-1:0] ID_OWNER = 3'h0;

   // hand-back delay after the reset pin rises
   localparam int CLK_PERIOD_PS = 4000;
   localparam int RETURN_PS = 20000;
   localparam int RETURN_CYCLES = (RETURN_PS / CLK_PERIOD_PS) < 1 ? 1 :
                                  (RETURN_PS / CLK_PERIOD_PS);
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

   typedef enum logic [1:0] {
      RSOC_HELD,
      RSOC_SETTLE,
      RSOC_RUN
   } rsoc_phase_t;
endpackage : rsoc_pkg

//--- core/rsoc_top.sv
`timescale 1ns/10ps
// Behaviour
// - sample all straps at reset pin rise
// - hold sampled strap levels in latches
// - hand pins back to function shortly after
// - weak default pulls while reset held
// - boot strap: 0 boot memory, 1 wait
// - irq strap: 0 off/level, 1 on/edge
// - link strap: 0 one-bit, 1 four-bit width
// - write strap: 0 write once, 1 always
// - pad resistor chosen from reset level
// - boot and lock pads pulled on id 0
module rsoc_top #(
   parameter int NPAD = rsoc_pkg::NPAD,
   parameter int NCFG = rsoc_pkg::NCFG,
   parameter int RETURN_CYCLES = rsoc_pkg::RETURN_CYCLES
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // device reset pin and identity
   input wire logic rst_in_n,
   input wire logic [rsoc_pkg::ID_W-1:0] mp_id,
   // shared pads
   input wire logic [NPAD-1:0] pad_in,
   output logic [NPAD-1:0] pad_out,
   output logic [NPAD-1:0] pad_oe,
   output logic [NPAD-1:0] pad_pull_up,
   output logic [NPAD-1:0] pad_pull_down,
   // normal pin functions from the core
   input wire logic [NPAD-1:0] func_out,
   input wire logic [NPAD-1:0] func_oe,
   // captured options and hand-back status
   output logic boot_source_strap,
   output logic interrupt_enable_strap,
   output logic link_width_strap,
   output logic config_write_strap,
   output logic test_strap_one,
   output logic test_strap_two,
   output logic test_strap_three,
   output logic pin_normal,
   // guarded configuration writes
   input wire logic [NCFG-1:0] cfg_wr,
   output logic [NCFG-1:0] cfg_wr_ok
);
   rsoc_pkg::rsoc_phase_t phase;
   rsoc_pkg::rsoc_phase_t next_phase;
   logic rst_prev;
   logic next_rst_prev;
   logic rise;
   logic [NPAD-1:0] strap;
   logic [NPAD-1:0] next_strap;
   logic [rsoc_pkg::CNT_W-1:0] cnt;
   logic [rsoc_pkg::CNT_W-1:0] next_cnt;
   logic next_pin_normal;
   logic id_zero;

   assign rise = rst_in_n & ~rst_prev;
   assign id_zero = (mp_id == rsoc_pkg::ID_OWNER);

   // release edge detect and strap latch
   always_comb begin
      next_rst_prev = rst_in_n;
      next_strap = strap;
      if (rise) begin
         next_strap = pad_in;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rst_prev <= 1'b0;
         strap <= rsoc_pkg::STRAP_DEFAULT;
      end else begin
         rst_prev <= next_rst_prev;
         strap <= next_strap;
      end
   end

   // option outputs, meaning of each is taken up by its consumer
   assign boot_source_strap = strap[rsoc_pkg::PAD_BOOT];
   assign interrupt_enable_strap = strap[rsoc_pkg::PAD_IRQ];
   assign link_width_strap = strap[rsoc_pkg::PAD_LINK];
   assign config_write_strap = strap[rsoc_pkg::PAD_CFGW];
   assign test_strap_one = strap[rsoc_pkg::PAD_TST1];
   assign test_strap_two = strap[rsoc_pkg::PAD_TST2];
   assign test_strap_three = strap[rsoc_pkg::PAD_TST3];

   // phase sequencer: held, settle, run
   always_comb begin
      next_phase = phase;
      next_cnt = cnt;
      case (phase)
         rsoc_pkg::RSOC_HELD: begin
            next_cnt = rsoc_pkg::CNT_ZERO;
            if (rise) begin
               next_phase = rsoc_pkg::RSOC_SETTLE;
               next_cnt = RETURN_CYCLES[rsoc_pkg::CNT_W-1:0];
            end
         end
         rsoc_pkg::RSOC_SETTLE: begin
            next_cnt = cnt - rsoc_pkg::CNT_ONE;
            if (cnt == rsoc_pkg::CNT_ONE) begin
               next_phase = rsoc_pkg::RSOC_RUN;
            end
         end
         rsoc_pkg::RSOC_RUN: begin
            next_cnt = rsoc_pkg::CNT_ZERO;
         end
         default: begin
            next_phase = rsoc_pkg::RSOC_HELD;
            next_cnt = rsoc_pkg::CNT_ZERO;
         end
      endcase
      if (!rst_in_n) begin
         next_phase = rsoc_pkg::RSOC_HELD;
         next_cnt = rsoc_pkg::CNT_ZERO;
      end
      next_pin_normal = (next_phase == rsoc_pkg::RSOC_RUN);
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         phase <= rsoc_pkg::RSOC_HELD;
         cnt <= rsoc_pkg::CNT_ZERO;
         pin_normal <= 1'b0;
      end else begin
         phase <= next_phase;
         cnt <= next_cnt;
         pin_normal <= next_pin_normal;
      end
   end

   // pads keep strap pulls until hand-back
   rsoc_pad_ctrl #(
      .NPAD(NPAD)
   ) rsoc_pad_ctrl_inst (
      .clock(clock),
      .reset(reset),
      .hold(!next_pin_normal),
      .id_zero(id_zero),
      .func_out(func_out),
      .func_oe(func_oe),
      .pad_out(pad_out),
      .pad_oe(pad_oe),
      .pad_pull_up(pad_pull_up),
      .pad_pull_down(pad_pull_down)
   );

   rsoc_cfg_guard #(
      .NCFG(NCFG)
   ) rsoc_cfg_guard_inst (
      .clock(clock),
      .reset(reset),
      .open(pin_normal),
      .clear(!pin_normal),
      .always_writable(config_write_strap),
      .cfg_wr(cfg_wr),
      .cfg_wr_ok(cfg_wr_ok)
   );

   // checks
   localparam int RET_DLY = RETURN_CYCLES + 1;
   logic sys_seen;

   // pull mask with the id-gated pads removed off the owner device
   function automatic logic [NPAD-1:0] id_gate(input logic [rsoc_pkg::ID_W-1:0] id);
      return (id == rsoc_pkg::ID_OWNER) ? {NPAD{1'b1}} : ~rsoc_pkg::ID_ZERO_ONLY;
   endfunction : id_gate

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sys_seen <= 1'b0;
      end else if (!pin_normal) begin
         sys_seen <= 1'b0;
      end else if (cfg_wr_ok[rsoc_pkg::CFG_SYS]) begin
         sys_seen <= 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_capture;
      rise |=> strap == $past(pad_in);
   endproperty
   a_capture: assert property (p_capture) else $error("strap not captured at release");

   property p_hold_latch;
      !rise |=> $stable(strap);
   endproperty
   a_hold_latch: assert property (p_hold_latch) else $error("strap moved without release");

   property p_return;
      $rose(pin_normal) |-> $past(rise, RET_DLY);
   endproperty
   a_return: assert property (p_return) else $error("pins returned at wrong time");

   property p_hold_pulls;
      !rst_in_n ##1 !rst_in_n |-> pad_oe == rsoc_pkg::ALL_ZERO
         && (pad_pull_up & ~rsoc_pkg::ID_ZERO_ONLY) == rsoc_pkg::HOLD_PULL_UP;
   endproperty
   a_hold_pulls: assert property (p_hold_pulls) else $error("pad not pulled in reset");

   property p_boot;
      rise |=> boot_source_strap == $past(pad_in[rsoc_pkg::PAD_BOOT]);
   endproperty
   a_boot: assert property (p_boot) else $error("boot strap wrong");

   property p_irq;
      rise |=> interrupt_enable_strap == $past(pad_in[rsoc_pkg::PAD_IRQ]);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt strap wrong");

   property p_link;
      rise |=> link_width_strap == $past(pad_in[rsoc_pkg::PAD_LINK]);
   endproperty
   a_link: assert property (p_link) else $error("link width strap wrong");

   property p_once;
      cfg_wr_ok[rsoc_pkg::CFG_SYS] && !config_write_strap |-> !sys_seen;
   endproperty
   a_once: assert property (p_once) else $error("second config write accepted");

   property p_always;
      cfg_wr[rsoc_pkg::CFG_SYS] && pin_normal && config_write_strap && rst_in_n
         |=> cfg_wr_ok[rsoc_pkg::CFG_SYS];
   endproperty
   a_always: assert property (p_always) else $error("write refused while always writable");

   property p_run_pads;
      pin_normal |-> pad_pull_down == rsoc_pkg::ALL_ZERO && pad_oe == $past(func_oe);
   endproperty
   a_run_pads: assert property (p_run_pads) else $error("pad not handed back");

   property p_id_pull;
      pin_normal |-> pad_pull_up ==
         ($past(mp_id) == rsoc_pkg::ID_OWNER ? rsoc_pkg::RUN_PULL_UP : rsoc_pkg::ALL_ZERO);
   endproperty
   a_id_pull: assert property (p_id_pull) else $error("id-gated pull wrong");

   property p_stable_run;
      pin_normal && $past(pin_normal) |-> $stable(strap);
   endproperty
   a_stable_run: assert property (p_stable_run) else $error("strap changed in operation");

   property p_held_pads;
      !pin_normal |-> pad_oe == rsoc_pkg::ALL_ZERO && pad_out == rsoc_pkg::ALL_ZERO;
   endproperty
   a_held_pads: assert property (p_held_pads) else $error("pad driven while held");

   property p_hold_down;
      !pin_normal ##1 !pin_normal
         |-> pad_pull_down == (rsoc_pkg::HOLD_PULL_DOWN & id_gate($past(mp_id)));
   endproperty
   a_hold_down: assert property (p_hold_down) else $error("strap pull-down wrong");

   property p_run_out;
      pin_normal |-> pad_out == $past(func_out);
   endproperty
   a_run_out: assert property (p_run_out) else $error("pad value not handed back");

   property p_drop;
      !rst_in_n |=> !pin_normal;
   endproperty
   a_drop: assert property (p_drop) else $error("pins kept after reset pin fell");

   property p_settle;
      rise |=> phase == rsoc_pkg::RSOC_SETTLE && cnt == RETURN_CYCLES[rsoc_pkg::CNT_W-1:0];
   endproperty
   a_settle: assert property (p_settle) else $error("settle count not loaded");

   property p_cnt_live;
      phase == rsoc_pkg::RSOC_SETTLE |-> cnt != rsoc_pkg::CNT_ZERO;
   endproperty
   a_cnt_live: assert property (p_cnt_live) else $error("settle count ran out");

   property p_cfgw;
      rise |=> config_write_strap == $past(pad_in[rsoc_pkg::PAD_CFGW]);
   endproperty
   a_cfgw: assert property (p_cfgw) else $error("write strap wrong");

   property p_tests;
      rise |=> {test_strap_three, test_strap_two, test_strap_one}
         == $past(pad_in[rsoc_pkg::PAD_TST3:rsoc_pkg::PAD_TST1]);
   endproperty
   a_tests: assert property (p_tests) else $error("test straps wrong");

   property p_no_wr_held;
      !pin_normal |=> cfg_wr_ok == {NCFG{1'b0}};
   endproperty
   a_no_wr_held: assert property (p_no_wr_held) else $error("early write grant");

   property p_ok_req;
      cfg_wr_ok[rsoc_pkg::CFG_SDRAM] |-> $past(cfg_wr[rsoc_pkg::CFG_SDRAM]);
   endproperty
   a_ok_req: assert property (p_ok_req) else $error("grant without request");

   property p_sdram_once;
      cfg_wr_ok[rsoc_pkg::CFG_SDRAM] && !config_write_strap |=> !cfg_wr_ok[rsoc_pkg::CFG_SDRAM];
   endproperty
   a_sdram_once: assert property (p_sdram_once) else $error("sdram written twice");

   property p_sdram_always;
      cfg_wr[rsoc_pkg::CFG_SDRAM] && pin_normal && config_write_strap && rst_in_n
         |=> cfg_wr_ok[rsoc_pkg::CFG_SDRAM];
   endproperty
   a_sdram_always: assert property (p_sdram_always) else $error("sdram write refused");

   c_release: cover property (rise ##1 strap != rsoc_pkg::STRAP_DEFAULT);
   c_handback: cover property ($rose(pin_normal));
   c_refused: cover property (cfg_wr[rsoc_pkg::CFG_SYS] && pin_normal && sys_seen
      && !config_write_strap);
   c_wait_boot: cover property (pin_normal && boot_source_strap);
   c_restart: cover property (phase == rsoc_pkg::RSOC_SETTLE && !rst_in_n);
endmodule : rsoc_top

//--- verif/reset_strap_option_capture_test.sv
`timescale 1ns/10ps
module reset_strap_option_capture_test;
   localparam int RC = 3;
   logic clock, reset, rst_in_n, pin_normal;
   logic [2:0] mp_id;
   logic [6:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
   logic [6:0] func_out, func_oe, drv_en, drv_val, exp_s, straps;
   logic s0, s1, s2, s3, s4, s5, s6;
   logic [1:0] cfg_wr, cfg_wr_ok;
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;
   integer seed = 32'h51AB3AA3;

   rsoc_top #(.RETURN_CYCLES(RC)) rsoc_top_inst (.clock(clock), .reset(reset),
      .rst_in_n(rst_in_n), .mp_id(mp_id), .pad_in(pad_in), .pad_out(pad_out),
      .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
      .func_out(func_out), .func_oe(func_oe), .boot_source_strap(s0),
      .interrupt_enable_strap(s1), .link_width_strap(s2), .config_write_strap(s3),
      .test_strap_one(s4), .test_strap_two(s5), .test_strap_three(s6),
      .pin_normal(pin_normal), .cfg_wr(cfg_wr), .cfg_wr_ok(cfg_wr_ok));
   rsoc_strap_board rsoc_strap_board_inst (.clock(clock), .pad_out(pad_out),
      .pad_oe(pad_oe), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
      .drive_en(drv_en), .drive_val(drv_val), .pad_in(pad_in));
   assign straps = {s6, s5, s4, s3, s2, s1, s0};

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out

   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         close_out();
      end
   end

   task automatic check(input logic [6:0] seen, input logic [6:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : step

   function automatic logic [6:0] exp_strap(input logic [6:0] en, input logic [6:0] v);
      return (en & v) | (~en & rsoc_pkg::STRAP_DEFAULT);
   endfunction : exp_strap

   // hold reset pin low with fresh straps, then release
   // corner 1: every pin left to its pull, corner 2: boot, irq, link and write straps overdriven high
   task automatic capture(input int corner);
      mp_id = (corner == 1 || ($random(seed) & 1)) ? 3'h0 : 3'($random(seed));
      drv_en = (corner == 1) ? 7'h00 : (corner == 2) ? 7'h0F : 7'($random(seed)) & 7'h0F;
      if (mp_id != 3'h0) drv_en = drv_en | 7'h09;
      drv_val = (corner == 2) ? 7'h7F : 7'($random(seed));
      rst_in_n = 1'b0;
      cfg_wr = 2'h3;
      step(3);
      check(pad_pull_down, (mp_id == 3'h0) ? 7'h0F : 7'h06);
      check(pad_pull_up, 7'h70);
      check(pad_oe, 7'h00);
      check(7'(cfg_wr_ok), 7'h00);
      cfg_wr = 2'h0;
      rst_in_n = 1'b1;
      exp_s = exp_strap(drv_en, drv_val);
      step(1);
      check(straps, exp_s);
      drv_val = ~drv_val;
      step(1);
      check(straps, exp_s);
   endtask : capture

   initial begin
      reset = 1'b1;
      rst_in_n = 1'b0;
      mp_id = 3'h0;
      func_out = 7'h00;
      func_oe = 7'h00;
      cfg_wr = 2'h0;
      drv_en = 7'h00;
      drv_val = 7'h00;
      step(6);
      check(straps, 7'h70);
      check(pad_pull_down, 7'h06);
      check(7'(pin_normal), 7'h00);
      reset = 1'b0;
      for (int i = 0; i < 16; i++) begin
         capture(i);
         if (i % 4 == 1) begin
            rst_in_n = 1'b0;
            step(2);
            check(7'(pin_normal), 7'h00);
            capture(0);
         end
         func_out = 7'($random(seed));
         func_oe = 7'($random(seed));
         step(RC - 2);
         check(7'(pin_normal), 7'h00);
         check(pad_oe, 7'h00);
         step(1);
         check(7'(pin_normal), 7'h01);
         check(pad_pull_down, 7'h00);
         check(pad_pull_up, (mp_id == 3'h0) ? 7'h09 : 7'h00);
         check(pad_oe, func_oe);
         check(pad_out, func_out);
         // boot, irq, link and write straps meet both levels over the run; test straps stay high
         check(straps, exp_s);
         cfg_wr = 2'h3;
         step(1);
         check(7'(cfg_wr_ok), 7'h03);
         step(1);
         check(7'(cfg_wr_ok), exp_s[3] ? 7'h03 : 7'h00);
         step(1);
         check(7'(cfg_wr_ok), exp_s[3] ? 7'h03 : 7'h00);
         cfg_wr = 2'h0;
         step(1);
         check(7'(cfg_wr_ok), 7'h00);
         $display("test %0d done", i);
      end
      // block reset in mid-run puts every output back to its reset value
      reset = 1'b1;
      step(2);
      check(straps, 7'h70);
      check(pad_pull_up, 7'h70);
      check(pad_pull_down, 7'h06);
      check(7'(pin_normal), 7'h00);
      check(7'(cfg_wr_ok), 7'h00);
      reset = 1'b0;
      capture(0);
      $display("test reset done");
      close_out();
   end
endmodule : reset_strap_option_capture_test

//--- verif/rsoc_strap_board.sv
`timescale 1ns/10ps
module rsoc_strap_board (
   // clock
   input wire logic clock,
   // device pad side
   input wire logic [6:0] pad_out,
   input wire logic [6:0] pad_oe,
   input wire logic [6:0] pad_pull_up,
   input wire logic [6:0] pad_pull_down,
   // board straps
   input wire logic [6:0] drive_en,
   input wire logic [6:0] drive_val,
   // resolved wire level
   output logic [6:0] pad_in
);
   logic flip = 1'b0;
   logic [6:0] board_en;

   always @(posedge clock) flip <= ~flip;
   // board never overdrives the test straps
   assign board_en = drive_en & 7'h0F;
   always_comb begin
      for (int i = 0; i < 7; i++) begin
         if (pad_oe[i]) pad_in[i] = pad_out[i];
         else if (board_en[i]) pad_in[i] = drive_val[i];
         else if (pad_pull_up[i]) pad_in[i] = 1'b1;
         else if (pad_pull_down[i]) pad_in[i] = 1'b0;
         // floating pad wanders every cycle
         else pad_in[i] = flip ^ i[0];
      end
   end
endmodule : rsoc_strap_board
